// file: common/dxf_pkg.sv
// Constants for the drop exchange fault control block
package dxf_pkg;
    localparam int          DROP_W        = 6;
    localparam logic [5:0]  MAX_DROP      = 6'h37;
    localparam int          REG_AW        = 6;
    localparam int          DEPTH_W       = 6;
    localparam logic [5:0]  DEPTH_BACK_ON = 6'h01;
    localparam int          DIAG_UNITS    = 10;
    // Shared memory map: outputs of slave 0-31, master outputs 32-63
    localparam logic [5:0]  SLV_OUT_LAST  = 6'h1F;
    localparam logic [5:0]  MST_OUT_FIRST = 6'h20;
    // Display codes, bit 7 is the trailing dash / runtime mark
    localparam logic [7:0]  CODE_NONE     = 8'hFF;
    localparam logic [7:0]  CODE_DIAG0    = 8'h00;
    localparam logic [7:0]  CODE_WDT_DIAG = 8'h0B;
    localparam logic [7:0]  CODE_DROP     = 8'h8A;
    localparam logic [7:0]  CODE_LINE     = 8'h8C;
    localparam logic [7:0]  CODE_SYS_WD   = 8'h0D;
    localparam logic [7:0]  CODE_POWER    = 8'h8E;
    localparam logic [7:0]  CODE_DMA_RT   = 8'h95;
    // Register port map, in words
    localparam logic [7:0]  A_CTRL        = 8'h40;
    localparam logic [7:0]  A_DEPTH       = 8'h41;
    localparam logic [7:0]  A_STAT        = 8'h42;
    localparam logic [7:0]  A_MASK        = 8'h43;
    localparam logic [7:0]  A_CODE        = 8'h44;
    localparam logic [7:0]  A_DROPST0     = 8'h45;
    localparam logic [7:0]  A_DROPST1     = 8'h46;
    localparam int          EV_W          = 5;
    localparam int          EV_LINE       = 0;
    localparam int          EV_DMA        = 1;
    localparam int          EV_SYS_WD     = 2;
    localparam int          EV_POWER      = 3;
    localparam int          EV_STOP       = 4;
    localparam int          CTRL_MASTER   = 0;
    localparam int          TX_TIMEOUT_NS = 2990000;
    localparam int          CLK_NS        = 10;
    localparam int          TX_TIMEOUT_CYC = TX_TIMEOUT_NS / CLK_NS;
    localparam int          TMO_W         = 19;
    localparam logic [31:0] MEM_RESET     = 32'h0000_0000;
    typedef enum logic [1:0] {
        ST_DIAG  = 2'b00,
        ST_RUN   = 2'b01,
        ST_CLEAR = 2'b10,
        ST_FAULT = 2'b11
    } dxf_state_t;
endpackage

// file: rtl/dxf_fault_ctrl.sv
// Drop exchange fault control: fault display, stop-all clear, exchange gating
`timescale 1ns/10ps
module dxf_fault_ctrl
#(
    parameter int TX_TIMEOUT = dxf_pkg::TX_TIMEOUT_CYC
)
(
    input  wire logic                        ref_clk_i,
    input  wire logic                        nrst_i,
    input  wire logic [dxf_pkg::DROP_W-1:0]  drop_sw_i,
    input  wire logic [dxf_pkg::DIAG_UNITS-1:0] diag_fail_i,
    input  wire logic                        diag_done_i,
    input  wire logic                        line_active_i,
    input  wire logic                        sys_wd_ok_i,
    input  wire logic                        low_volt_i,
    input  wire logic                        stop_all_i,
    input  wire logic                        tx_start_i,
    input  wire logic                        tx_done_i,
    input  wire logic                        rx_valid_i,
    input  wire logic [dxf_pkg::REG_AW-1:0]  rx_addr_i,
    input  wire logic [31:0]                 rx_data_i,
    input  wire logic [dxf_pkg::DROP_W-1:0]  rx_drop_i,
    input  wire logic                        rx_virtual_i,
    input  wire logic [dxf_pkg::REG_AW-1:0]  tx_addr_i,
    input  wire logic [7:0]                  addr_i,
    input  wire logic [31:0]                 wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [31:0]                 rdata_o,
    output logic      [31:0]                 tx_data_o,
    output logic                             link_en_o,
    output logic      [7:0]                  fault_code_o,
    output logic      [dxf_pkg::DROP_W-1:0]  drop_num_o,
    output logic                             irq_o
);
    logic [31:0]                   mem_r [0:63];
    logic [dxf_pkg::DROP_W-1:0]    drop_r;
    logic                          sampled_r;
    logic [dxf_pkg::DEPTH_W-1:0]   depth_r;
    logic                          depth_prog_r;
    logic                          master_r;
    logic [dxf_pkg::EV_W-1:0]      stat_r;
    logic [dxf_pkg::EV_W-1:0]      mask_r;
    logic [63:0]                   drop_st_r;
    logic                          line_fail_r;
    logic                          dma_fail_r;
    logic                          busy_r;
    logic [dxf_pkg::TMO_W-1:0]     tmo_r;
    logic [7:0]                    code_nxt;
    logic [dxf_pkg::EV_W-1:0]      ev;
    logic                          depth_wr;
    logic                          depth_ok;
    logic                          diag_bad;
    logic                          drop_bad;
    logic                          ex_ok;
    logic                          tx_ok;
    logic                          depth_set;
    logic                          ctrl_wr;
    logic                          mask_wr;
    logic                          stat_wr;
    logic                          mem_rd;
    logic                          rx_take;
    logic                          take_mst;
    logic                          take_slv;
    logic                          tmo_hit;
    logic [31:0]                   rdata_nxt;
    logic [7:0]                    diag_code [0:dxf_pkg::DIAG_UNITS];
    dxf_pkg::dxf_state_t           state_r;
    dxf_pkg::dxf_state_t           state_nxt;

    assign depth_wr  = wr_i && (addr_i == dxf_pkg::A_DEPTH);
    assign depth_ok  = (wdata_i[dxf_pkg::DEPTH_W-1:0] != '0);
    assign depth_set = depth_wr && depth_ok;
    assign ctrl_wr   = wr_i && (addr_i == dxf_pkg::A_CTRL);
    assign mask_wr   = wr_i && (addr_i == dxf_pkg::A_MASK);
    assign stat_wr   = wr_i && (addr_i == dxf_pkg::A_STAT);
    assign mem_rd    = (addr_i < dxf_pkg::A_CTRL);
    assign diag_bad  = |diag_fail_i;
    assign drop_bad  = (drop_r > dxf_pkg::MAX_DROP);
    assign link_en_o = (state_r == dxf_pkg::ST_RUN) && sys_wd_ok_i;
    // Exchange allowed only on base drop, never virtual, and only once depth is programmed
    assign ex_ok     = link_en_o && depth_prog_r && !rx_virtual_i;
    // Sending must not hang on the receive side's qualifiers
    assign tx_ok     = link_en_o && depth_prog_r;
    assign rx_take   = rx_valid_i && ex_ok;
    assign take_mst  = rx_take && master_r && (rx_addr_i <= dxf_pkg::SLV_OUT_LAST);
    assign take_slv  = rx_take && !master_r && (rx_addr_i >= dxf_pkg::MST_OUT_FIRST);
    assign tmo_hit   = (tmo_r == dxf_pkg::TMO_W'(TX_TIMEOUT - 1));

    // Lowest failing unit wins the display
    assign diag_code[dxf_pkg::DIAG_UNITS] = dxf_pkg::CODE_DIAG0;
    generate
        for (genvar u = 0; u < dxf_pkg::DIAG_UNITS; u++)
        begin : g_diag
            if (u == dxf_pkg::DIAG_UNITS - 1)
            begin : g_wdt
                assign diag_code[u] = diag_fail_i[u] ? dxf_pkg::CODE_WDT_DIAG
                                                     : diag_code[u+1];
            end
            else
            begin : g_unit
                assign diag_code[u] = diag_fail_i[u] ? (dxf_pkg::CODE_DIAG0 | 8'(u))
                                                     : diag_code[u+1];
            end
        end
    endgenerate

    // Next control state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            dxf_pkg::ST_DIAG:
                if (diag_done_i)
                    state_nxt = diag_bad ? dxf_pkg::ST_FAULT : dxf_pkg::ST_RUN;
            dxf_pkg::ST_RUN:
                if (stop_all_i)
                    state_nxt = dxf_pkg::ST_CLEAR;
            dxf_pkg::ST_CLEAR:
                state_nxt = dxf_pkg::ST_RUN;
            dxf_pkg::ST_FAULT:
                state_nxt = dxf_pkg::ST_FAULT;
            default:
                state_nxt = dxf_pkg::ST_DIAG;
        endcase
    end

    // Control state
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            state_r <= dxf_pkg::ST_DIAG;
        else
            state_r <= state_nxt;
    end

    // Drop switch capture once after reset
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            sampled_r <= 1'b0;
            drop_r    <= '0;
        end
        else if (!sampled_r)
        begin
            sampled_r <= 1'b1;
            drop_r    <= drop_sw_i;
        end
    end
    assign drop_num_o = drop_r;

    // Master or slave mode
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            master_r <= 1'b0;
        else if (ctrl_wr)
            master_r <= wdata_i[dxf_pkg::CTRL_MASTER];
    end

    // Drop depth, cleared by stop-all
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i || stop_all_i)
        begin
            depth_r      <= '0;
            depth_prog_r <= 1'b0;
        end
        else if (depth_set)
        begin
            depth_r      <= wdata_i[dxf_pkg::DEPTH_W-1:0];
            depth_prog_r <= 1'b1;
        end
    end

    // Shared memory: clear on stop-all, refill from the link
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i || state_r == dxf_pkg::ST_CLEAR || stop_all_i)
        begin
            for (int i = 0; i < 64; i++)
                mem_r[i] <= dxf_pkg::MEM_RESET;
        end
        else if (take_mst || take_slv)
        begin
            // Master takes slave outputs, slave takes master outputs
            mem_r[rx_addr_i] <= rx_data_i;
        end
    end

    // Outgoing data; zero while cleared memory is resent
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            tx_data_o <= '0;
        else
            tx_data_o <= tx_ok ? mem_r[tx_addr_i] : '0;
    end

    // Drop status bits, set only once depth is programmed
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i || stop_all_i)
            drop_st_r <= '0;
        else if (master_r && rx_take)
            drop_st_r[rx_drop_i] <= 1'b1;
        else if (!master_r && depth_prog_r)
            drop_st_r[drop_r] <= 1'b1;
    end

    // Line failure
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            line_fail_r <= 1'b0;
        else if (line_active_i || depth_set)
            line_fail_r <= 1'b0;
        else if (state_r == dxf_pkg::ST_RUN && depth_prog_r)
            line_fail_r <= 1'b1;
    end

    // Transmit timeout watch
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            busy_r <= 1'b0;
            tmo_r  <= '0;
        end
        else if (tx_start_i)
        begin
            busy_r <= 1'b1;
            tmo_r  <= '0;
        end
        else if (busy_r && (tx_done_i || tmo_hit))
            busy_r <= 1'b0;
        else if (busy_r)
            tmo_r <= tmo_r + 1'b1;
    end

    // Runtime transmit fault, held until the next start
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i || tx_start_i)
            dma_fail_r <= 1'b0;
        else if (busy_r && !tx_done_i && tmo_hit)
            dma_fail_r <= 1'b1;
    end

    // Displayed code, highest priority first
    always_comb
    begin
        code_nxt = dxf_pkg::CODE_NONE;
        if (low_volt_i)
            code_nxt = dxf_pkg::CODE_POWER;
        else if (state_r == dxf_pkg::ST_FAULT)
            code_nxt = diag_code[0];
        else if (drop_bad)
            code_nxt = dxf_pkg::CODE_DROP;
        else if (!sys_wd_ok_i)
            code_nxt = dxf_pkg::CODE_SYS_WD;
        else if (dma_fail_r)
            code_nxt = dxf_pkg::CODE_DMA_RT;
        else if (line_fail_r)
            code_nxt = dxf_pkg::CODE_LINE;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            fault_code_o <= dxf_pkg::CODE_NONE;
        else
            fault_code_o <= code_nxt;
    end

    // Interrupt events: set wins over write-one clear
    assign ev = {stop_all_i, low_volt_i, !sys_wd_ok_i, dma_fail_r, line_fail_r};
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            mask_r <= '0;
        else if (mask_wr)
            mask_r <= wdata_i[dxf_pkg::EV_W-1:0];
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            stat_r <= '0;
        else if (stat_wr)
            stat_r <= (stat_r & ~wdata_i[dxf_pkg::EV_W-1:0]) | ev;
        else
            stat_r <= stat_r | ev;
    end
    assign irq_o = |(stat_r & mask_r);

    // Register read decode
    always_comb
    begin
        rdata_nxt = '0;
        if (rd_i && mem_rd)
            rdata_nxt = mem_r[addr_i[dxf_pkg::REG_AW-1:0]];
        else if (rd_i)
        begin
            case (addr_i)
                dxf_pkg::A_CTRL:    rdata_nxt = {31'h0, master_r};
                dxf_pkg::A_DEPTH:   rdata_nxt = {26'h0, depth_r};
                dxf_pkg::A_STAT:    rdata_nxt = {27'h0, stat_r};
                dxf_pkg::A_MASK:    rdata_nxt = {27'h0, mask_r};
                dxf_pkg::A_CODE:    rdata_nxt = {18'h0, drop_r, fault_code_o};
                dxf_pkg::A_DROPST0: rdata_nxt = drop_st_r[31:0];
                dxf_pkg::A_DROPST1: rdata_nxt = drop_st_r[63:32];
                default:            rdata_nxt = '0;
            endcase
        end
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            rdata_o <= '0;
        else
            rdata_o <= rdata_nxt;
    end
endmodule

// file: dv/dxf_fault_ctrl_props.sv
// Port assertions for the fault control block
`timescale 1ns/10ps
module dxf_fault_ctrl_props
#(
    parameter int TX_TIMEOUT = 20
)
(
    input wire logic                       ref_clk_i,
    input wire logic                       nrst_i,
    input wire logic                       line_active_i,
    input wire logic                       sys_wd_ok_i,
    input wire logic                       low_volt_i,
    input wire logic                       stop_all_i,
    input wire logic [7:0]                 addr_i,
    input wire logic                       wr_i,
    input wire logic                       rd_i,
    input wire logic [31:0]                rdata_o,
    input wire logic                       link_en_o,
    input wire logic [7:0]                 fault_code_o,
    input wire logic [dxf_pkg::DROP_W-1:0] drop_num_o,
    input wire logic                       irq_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);
    sequence s_stop_quiet;
        stop_all_i ##1 !wr_i [*2];
    endsequence
    sequence s_mem_read;
        rd_i && addr_i < dxf_pkg::A_CTRL;
    endsequence
    a_reset_idle: assert property ($rose(nrst_i) |->
        fault_code_o == dxf_pkg::CODE_NONE && !irq_o) else $error("Not idle after reset");
    a_stop_clears: assert property (s_stop_quiet ##0 s_mem_read |=>
        rdata_o == 32'h0) else $error("Memory not cleared by stop-all");
    a_wd_blocks_link: assert property (!sys_wd_ok_i |->
        !link_en_o) else $error("Link enabled with watchdog down");
    a_wd_code_shown: assert property ($past(link_en_o) && $fell(sys_wd_ok_i) && !low_volt_i |->
        ##[0:2] fault_code_o == dxf_pkg::CODE_SYS_WD) else $error("Watchdog code missing");
    a_power_shown: assert property (low_volt_i [*3] |->
        fault_code_o == dxf_pkg::CODE_POWER) else $error("Power code missing");
    a_line_cleared: assert property (line_active_i [*3] |->
        fault_code_o != dxf_pkg::CODE_LINE) else $error("Line code kept with activity");
    a_drop_held: assert property ($past(nrst_i, 2) |->
        $stable(drop_num_o)) else $error("Drop number changed after capture");
    a_drop_code: assert property (fault_code_o == dxf_pkg::CODE_DROP |->
        drop_num_o > dxf_pkg::MAX_DROP) else $error("Drop code on valid drop");
endmodule
bind dxf_fault_ctrl dxf_fault_ctrl_props #(.TX_TIMEOUT(TX_TIMEOUT)) i_props
(
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .line_active_i(line_active_i),
    .sys_wd_ok_i(sys_wd_ok_i), .low_volt_i(low_volt_i), .stop_all_i(stop_all_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_en_o(link_en_o),
    .fault_code_o(fault_code_o), .drop_num_o(drop_num_o), .irq_o(irq_o)
);

// file: dv/dxf_peer_drop.sv
// Model of a peer drop on the network side
`timescale 1ns/10ps
module dxf_peer_drop
(
    input  wire logic        ref_clk_i,
    input  wire logic        silent_i,
    output logic             line_active_o,
    output logic             rx_valid_o,
    output logic [5:0]       rx_addr_o,
    output logic [31:0]      rx_data_o,
    output logic [5:0]       rx_drop_o,
    output logic             rx_virtual_o
);
    assign line_active_o = !silent_i;
    assign rx_drop_o = 6'h06;
    initial
    begin
        rx_valid_o = 1'b0;
        rx_addr_o = 6'h3F;
        rx_data_o = 32'hFFFF_FFFF;
        rx_virtual_o = 1'b0;
    end
    // One word per call; released lines show the inverse
    task automatic send(input logic [5:0] a, input logic [31:0] v, input logic virt);
        @(posedge ref_clk_i);
        rx_valid_o <= 1'b1;
        rx_addr_o <= a;
        rx_data_o <= v;
        rx_virtual_o <= virt;
        @(posedge ref_clk_i);
        rx_valid_o <= 1'b0;
        rx_addr_o <= ~a;
        rx_data_o <= ~v;
        rx_virtual_o <= ~virt;
    endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the drop exchange fault control block
`timescale 1ns/10ps
module testbench;
    logic        ref_clk   = 1'b0;
    logic        nrst      = 1'b0;
    logic [5:0]  drop_sw   = 6'h05;
    logic [9:0]  diag_fail = 10'h000;
    logic        diag_done = 1'b0;
    logic        sys_wd_ok = 1'b1;
    logic        low_volt  = 1'b0;
    logic        stop_all  = 1'b0;
    logic        tx_start  = 1'b0;
    logic        tx_done   = 1'b0;
    logic [5:0]  tx_addr   = 6'h03;
    logic        silent    = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic [31:0] wdata     = 32'h0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        line_act, rx_valid, rx_virt, link_en, irq;
    logic [5:0]  rx_addr, rx_drop, drop_num;
    logic [31:0] rx_data, rdata, tx_data, d;
    logic [7:0]  code;
    int          failures  = 0;
    int          total_checks = 0;
    always #5 ref_clk = ~ref_clk;
    dxf_peer_drop i_peer (.ref_clk_i(ref_clk), .silent_i(silent), .line_active_o(line_act),
        .rx_valid_o(rx_valid), .rx_addr_o(rx_addr), .rx_data_o(rx_data),
        .rx_drop_o(rx_drop), .rx_virtual_o(rx_virt));
    dxf_fault_ctrl #(.TX_TIMEOUT(20)) i_dut (.ref_clk_i(ref_clk), .nrst_i(nrst),
        .drop_sw_i(drop_sw), .diag_fail_i(diag_fail), .diag_done_i(diag_done),
        .line_active_i(line_act), .sys_wd_ok_i(sys_wd_ok), .low_volt_i(low_volt),
        .stop_all_i(stop_all), .tx_start_i(tx_start), .tx_done_i(tx_done),
        .rx_valid_i(rx_valid), .rx_addr_i(rx_addr), .rx_data_i(rx_data),
        .rx_drop_i(rx_drop), .rx_virtual_i(rx_virt), .tx_addr_i(tx_addr), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_data_o(tx_data),
        .link_en_o(link_en), .fault_code_o(code), .drop_num_o(drop_num), .irq_o(irq));
    task automatic complete_run();
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        failures += (got !== exp);
        if (got !== exp) $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    endtask
    task automatic wait_code(input logic [7:0] c, input int n);
        for (int k = 0; k < n && code !== c; k++) @(posedge ref_clk);
        chk({24'h0, code}, {24'h0, c});
        if (code !== c) complete_run();
    endtask
    task automatic boot(input logic [5:0] sw, input logic [9:0] fl);
        nrst <= 1'b0;
        drop_sw <= sw;
        diag_fail <= fl;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        drop_sw <= ~sw;
        diag_done <= 1'b1;
        @(posedge ref_clk);
        diag_done <= 1'b0;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
        v = rdata;
    endtask
    initial
    begin
        for (int i = 0; i < 10; i++)
        begin
            boot(6'h05, 10'h001 << i);
            wait_code((i == 9) ? dxf_pkg::CODE_WDT_DIAG : dxf_pkg::CODE_DIAG0 | 8'(i), 8);
        end
        boot(6'h38, 10'h000);
        wait_code(dxf_pkg::CODE_DROP, 8);
        boot(6'h37, 10'h000);
        wait_code(dxf_pkg::CODE_NONE, 8);
        chk({26'h0, drop_num}, 32'h37);
        reg_rd(dxf_pkg::A_DEPTH, d);
        chk(d, 32'h0);
        reg_rd(8'h7F, d);
        chk(d, 32'h0);
        reg_wr(dxf_pkg::A_CTRL, 32'h1);
        reg_wr(dxf_pkg::A_DEPTH, 32'h0);
        reg_rd(dxf_pkg::A_DEPTH, d);
        chk(d, 32'h0);
        reg_wr(dxf_pkg::A_MASK, 32'h1);
        silent <= 1'b1;
        reg_wr(dxf_pkg::A_DEPTH, {26'h0, dxf_pkg::DEPTH_BACK_ON});
        wait_code(dxf_pkg::CODE_LINE, 8);
        silent <= 1'b0;
        wait_code(dxf_pkg::CODE_NONE, 8);
        chk({31'h0, irq}, 32'h1);
        reg_wr(dxf_pkg::A_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        reg_wr(dxf_pkg::A_MASK, 32'h1);
        reg_wr(dxf_pkg::A_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        i_peer.send(6'h03, 32'hA5A5_0003, 1'b0);
        i_peer.send(6'h21, 32'hA5A5_0021, 1'b0);
        i_peer.send(6'h04, 32'hA5A5_0004, 1'b1);
        reg_rd(8'h03, d);
        chk(d, 32'hA5A5_0003);
        reg_rd(8'h21, d);
        chk(d, 32'h0);
        reg_rd(8'h04, d);
        chk(d, 32'h0);
        reg_rd(dxf_pkg::A_DROPST0, d);
        chk(d, 32'h0000_0040);
        stop_all <= 1'b1;
        @(posedge ref_clk);
        stop_all <= 1'b0;
        @(posedge ref_clk);
        reg_rd(8'h03, d);
        chk(d, 32'h0);
        chk(tx_data, 32'h0);
        i_peer.send(6'h05, 32'h5A5A_0005, 1'b0);
        reg_rd(8'h05, d);
        chk(d, 32'h0);
        reg_rd(dxf_pkg::A_DROPST0, d);
        chk(d, 32'h0);
        reg_wr(dxf_pkg::A_DEPTH, 32'h1);
        i_peer.send(6'h05, 32'h5A5A_0005, 1'b0);
        reg_rd(8'h05, d);
        chk(d, 32'h5A5A_0005);
        reg_wr(dxf_pkg::A_CTRL, 32'h0);
        i_peer.send(6'h22, 32'h5A5A_0022, 1'b0);
        reg_rd(8'h22, d);
        chk(d, 32'h5A5A_0022);
        reg_rd(dxf_pkg::A_DROPST1, d);
        chk(d, 32'h0080_0000);
        chk({31'h0, link_en}, 32'h1);
        tx_addr <= 6'h22;
        repeat (2) @(posedge ref_clk);
        chk(tx_data, 32'h5A5A_0022);
        sys_wd_ok <= 1'b0;
        wait_code(dxf_pkg::CODE_SYS_WD, 8);
        chk({31'h0, link_en}, 32'h0);
        i_peer.send(6'h23, 32'h5A5A_0023, 1'b0);
        reg_rd(8'h23, d);
        chk(d, 32'h0);
        sys_wd_ok <= 1'b1;
        wait_code(dxf_pkg::CODE_NONE, 8);
        tx_start <= 1'b1;
        @(posedge ref_clk);
        tx_start <= 1'b0;
        repeat (5) @(posedge ref_clk);
        tx_done <= 1'b1;
        @(posedge ref_clk);
        tx_done <= 1'b0;
        repeat (30) @(posedge ref_clk);
        chk({24'h0, code}, {24'h0, dxf_pkg::CODE_NONE});
        tx_start <= 1'b1;
        @(posedge ref_clk);
        tx_start <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk({24'h0, code}, {24'h0, dxf_pkg::CODE_NONE});
        wait_code(dxf_pkg::CODE_DMA_RT, 40);
        low_volt <= 1'b1;
        wait_code(dxf_pkg::CODE_POWER, 8);
        complete_run();
    end
endmodule
